// *** rtl/ssm_pkg.sv ***
package ssm_pkg;
  // shared memory geometry
  localparam int MEM_BYTES = 65536;
  localparam int WORD_BYTES = 4;
  localparam int MEM_WORDS = MEM_BYTES / WORD_BYTES;
  localparam int PTR_W = $clog2(MEM_WORDS);
  localparam int DATA_W = 32;
  localparam int REG_ADDR_W = 8;
  localparam int NUM_RATES = 3;

  // register byte offsets
  localparam logic [REG_ADDR_W-1:0] OFS_PTR = 8'h00;
  localparam logic [REG_ADDR_W-1:0] OFS_DAT = 8'h04;
  localparam logic [REG_ADDR_W-1:0] OFS_DATINC = 8'h08;
  localparam logic [REG_ADDR_W-1:0] OFS_FLAGS = 8'h0C;
  localparam logic [REG_ADDR_W-1:0] OFS_BASE = 8'h10;
  localparam logic [REG_ADDR_W-1:0] OFS_RATE = 8'h14;
  localparam logic [REG_ADDR_W-1:0] OFS_CTRL = 8'h18;
  localparam logic [REG_ADDR_W-1:0] OFS_STATUS = 8'h1C;

  // lane rate codes
  localparam logic [1:0] RATE_FULL = 2'h0;
  localparam logic [1:0] RATE_HALF = 2'h1;
  localparam logic [1:0] RATE_QUARTER = 2'h2;

  // field positions
  localparam int CTRL_MCU_RUN = 0;
  localparam int ST_MCU_RUN = 0;
  localparam int ST_BASE_DONE = 1;
  localparam int ST_RATE_VALID = 2;
  localparam int ST_RATE_ERR = 3;
  localparam int RATE_ERR_BIT = 8;

  // reset values
  localparam logic [PTR_W-1:0] RST_PTR = 14'h0000;
  localparam logic [DATA_W-1:0] RST_FLAGS = 32'h0000_0000;
  localparam logic [NUM_RATES-1:0] RST_RATE_OK = 3'h0;
  localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

  typedef struct packed {
    logic [REG_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ssm_bus_req_t;

  typedef struct packed {
    logic [PTR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic en;
    logic we;
  } ssm_mcu_req_t;

  typedef struct packed {
    logic mcu_run;
    logic [DATA_W-1:0] cfg_flags;
    logic [1:0] lane_rate;
    logic rate_valid;
  } ssm_ctl_out_t;

  typedef struct packed {
    logic [PTR_W-1:0] ptr;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] mcu_rdata;
    logic [DATA_W-1:0] flags;
    logic base_done;
    logic [NUM_RATES-1:0] rate_ok;
    logic [1:0] rate;
    logic rate_valid;
    logic rate_err;
    logic mcu_run;
  } ssm_state_t;
endpackage : ssm_pkg

// *** rtl/ssm_mem.sv ***
`timescale 1ns/100ps
module ssm_mem #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic a_we,
  input wire logic [ADDR_W-1:0] a_addr,
  input wire logic [DATA_W-1:0] a_wdata,
  output logic [DATA_W-1:0] a_rdata,
  input wire logic b_we,
  input wire logic [ADDR_W-1:0] b_addr,
  input wire logic [DATA_W-1:0] b_wdata,
  output logic [DATA_W-1:0] b_rdata
);
  logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];

  assign a_rdata = mem[a_addr];
  assign b_rdata = mem[b_addr];

  // port a wins a same-word collision
  always_ff @(posedge clk)
  begin
    if (a_we)
    begin
      mem[a_addr] <= a_wdata;
    end
    if (b_we && !(a_we && (a_addr == b_addr)))
    begin
      mem[b_addr] <= b_wdata;
    end
  end
endmodule : ssm_mem

// *** rtl/ssm_portal.sv ***
// Chosen here: the address map and the strobed register port.
`timescale 1ns/100ps
module ssm_portal (
  input wire logic clk,
  input wire logic nrst,
  input wire ssm_pkg::ssm_bus_req_t bus_req,
  output logic [ssm_pkg::DATA_W-1:0] bus_rdata,
  input wire ssm_pkg::ssm_mcu_req_t mcu_req,
  output logic [ssm_pkg::DATA_W-1:0] mcu_rdata,
  output ssm_pkg::ssm_ctl_out_t ctl_out
);
  import ssm_pkg::*;

  ssm_state_t st;
  ssm_state_t next_st;
  logic [DATA_W-1:0] host_word;
  logic [DATA_W-1:0] mcu_word;
  logic host_we;
  logic mcu_we;
  logic sel_dat;
  logic sel_inc;
  logic mapped;
  logic [DATA_W-1:0] rd_mux;

  // decode of the window registers
  assign sel_dat = (bus_req.addr == OFS_DAT);
  assign sel_inc = (bus_req.addr == OFS_DATINC);
  assign host_we = bus_req.wr && (sel_dat || sel_inc);
  // firmware port active only once the microcontroller is started
  assign mcu_we = mcu_req.en && mcu_req.we && st.mcu_run;

  // shared store, no path from the system map other than the window
  ssm_mem #(
    .ADDR_W(PTR_W),
    .DATA_W(DATA_W)
  ) u_mem (
    .clk(clk),
    .a_we(host_we),
    .a_addr(st.ptr),
    .a_wdata(bus_req.wdata),
    .a_rdata(host_word),
    .b_we(mcu_we),
    .b_addr(mcu_req.addr),
    .b_wdata(mcu_req.wdata),
    .b_rdata(mcu_word)
  );

  // read mux
  always_comb
  begin
    rd_mux = RST_RDATA;
    mapped = 1'b1;
    case (bus_req.addr)
      OFS_PTR: rd_mux = DATA_W'(st.ptr);
      OFS_DAT: rd_mux = host_word;
      OFS_DATINC: rd_mux = host_word;
      OFS_FLAGS: rd_mux = st.flags;
      OFS_BASE: rd_mux = DATA_W'(st.rate_ok);
      OFS_RATE:
      begin
        rd_mux = DATA_W'(st.rate);
        rd_mux[RATE_ERR_BIT] = st.rate_err;
      end
      OFS_CTRL: rd_mux[CTRL_MCU_RUN] = st.mcu_run;
      OFS_STATUS:
      begin
        rd_mux[ST_MCU_RUN] = st.mcu_run;
        rd_mux[ST_BASE_DONE] = st.base_done;
        rd_mux[ST_RATE_VALID] = st.rate_valid;
        rd_mux[ST_RATE_ERR] = st.rate_err;
      end
      default: mapped = 1'b0;
    endcase
  end

  // next state
  always_comb
  begin
    next_st = st;
    next_st.rdata = RST_RDATA;
    if (bus_req.rd)
    begin
      next_st.rdata = mapped ? rd_mux : RST_RDATA;
    end
    if (mcu_req.en && !mcu_req.we && st.mcu_run)
    begin
      next_st.mcu_rdata = mcu_word;
    end
    if ((bus_req.rd || bus_req.wr) && sel_inc)
    begin
      next_st.ptr = PTR_W'(st.ptr + 1'b1);
    end
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        OFS_PTR: next_st.ptr = bus_req.wdata[PTR_W-1:0];
        OFS_FLAGS: next_st.flags = bus_req.wdata;
        OFS_BASE:
        begin
          // new base configuration forces a fresh rate choice
          next_st.rate_ok = bus_req.wdata[NUM_RATES-1:0];
          next_st.base_done = 1'b1;
          next_st.rate_valid = 1'b0;
        end
        OFS_RATE:
        begin
          if (st.base_done && (bus_req.wdata[1:0] != 2'h3) &&
              st.rate_ok[bus_req.wdata[1:0]])
          begin
            next_st.rate = bus_req.wdata[1:0];
            next_st.rate_valid = 1'b1;
          end
          else
          begin
            next_st.rate_err = 1'b1;
          end
        end
        OFS_CTRL: next_st.mcu_run = bus_req.wdata[CTRL_MCU_RUN];
        OFS_STATUS:
        begin
          if (bus_req.wdata[ST_RATE_ERR])
          begin
            next_st.rate_err = 1'b0;
          end
        end
        default: next_st.ptr = next_st.ptr;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st.ptr <= RST_PTR;
      st.rdata <= RST_RDATA;
      st.mcu_rdata <= RST_RDATA;
      st.flags <= RST_FLAGS;
      st.base_done <= 1'b0;
      st.rate_ok <= RST_RATE_OK;
      st.rate <= RATE_FULL;
      st.rate_valid <= 1'b0;
      st.rate_err <= 1'b0;
      st.mcu_run <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign bus_rdata = st.rdata;
  assign mcu_rdata = st.mcu_rdata;
  assign ctl_out.mcu_run = st.mcu_run;
  assign ctl_out.cfg_flags = st.flags;
  assign ctl_out.lane_rate = st.rate;
  assign ctl_out.rate_valid = st.rate_valid;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_ptr_write: assert property (
    bus_req.wr && bus_req.addr == OFS_PTR |=> st.ptr == $past(bus_req.wdata[PTR_W-1:0]))
    else $error("pointer write not taken");

  chk_inc_advance: assert property (
    (bus_req.wr || bus_req.rd) && sel_inc |=> st.ptr == PTR_W'($past(st.ptr) + 1'b1))
    else $error("auto-increment pointer did not advance");

  chk_plain_hold: assert property (
    (bus_req.wr || bus_req.rd) && sel_dat |=> st.ptr == $past(st.ptr))
    else $error("plain window moved the pointer");

  chk_plain_store: assert property (
    bus_req.wr && sel_dat |=> host_word == $past(bus_req.wdata))
    else $error("window write not stored");

  chk_window_read: assert property (
    bus_req.rd && (sel_dat || sel_inc) |=> bus_rdata == $past(host_word))
    else $error("window read data wrong");

  chk_unmapped_zero: assert property (
    bus_req.rd && !mapped |=> bus_rdata == RST_RDATA)
    else $error("unmapped read not zero");

  chk_rate_legal: assert property (
    st.rate_valid |-> st.base_done && st.rate != 2'h3 && st.rate_ok[st.rate])
    else $error("unsupported lane rate active");

  chk_flags_out: assert property (
    bus_req.wr && bus_req.addr == OFS_FLAGS |=> ctl_out.cfg_flags == $past(bus_req.wdata))
    else $error("flags not presented");

  chk_mcu_read: assert property (
    mcu_req.en && !mcu_req.we && st.mcu_run |=> mcu_rdata == $past(mcu_word))
    else $error("firmware read data wrong");

  chk_mcu_hold: assert property (
    !(mcu_req.en && !mcu_req.we && st.mcu_run) |=> mcu_rdata == $past(mcu_rdata))
    else $error("firmware read data moved without a read");

  chk_rate_no_base: assert property (
    bus_req.wr && bus_req.addr == OFS_RATE && !st.base_done |=>
    st.rate_err && !st.rate_valid)
    else $error("rate taken before base configuration");

  chk_rate_code3: assert property (
    bus_req.wr && bus_req.addr == OFS_RATE && bus_req.wdata[1:0] == 2'h3 |=>
    st.rate_err && st.rate == $past(st.rate))
    else $error("reserved rate code accepted");

  chk_rate_taken: assert property (
    bus_req.wr && bus_req.addr == OFS_RATE && st.base_done &&
    bus_req.wdata[1:0] != 2'h3 && st.rate_ok[bus_req.wdata[1:0]] |=>
    st.rate_valid && ctl_out.lane_rate == $past(bus_req.wdata[1:0]))
    else $error("supported rate not taken");

  chk_base_load: assert property (
    bus_req.wr && bus_req.addr == OFS_BASE |=>
    st.base_done && !st.rate_valid && st.rate_ok == $past(bus_req.wdata[NUM_RATES-1:0]))
    else $error("base configuration not loaded");

  chk_err_clear: assert property (
    bus_req.wr && bus_req.addr == OFS_STATUS && bus_req.wdata[ST_RATE_ERR] |=>
    !st.rate_err)
    else $error("rate error not cleared");

  chk_rdata_idle: assert property (
    !bus_req.rd |=> bus_rdata == RST_RDATA)
    else $error("read data outside its cycle");

  chk_ptr_hold: assert property (
    !(bus_req.wr && bus_req.addr == OFS_PTR) && !((bus_req.wr || bus_req.rd) && sel_inc) |=>
    st.ptr == $past(st.ptr))
    else $error("pointer moved without cause");

  chk_flags_hold: assert property (
    !(bus_req.wr && bus_req.addr == OFS_FLAGS) |=>
    ctl_out.cfg_flags == $past(ctl_out.cfg_flags))
    else $error("flags changed without a write");

  chk_run_ctrl: assert property (
    bus_req.wr && bus_req.addr == OFS_CTRL |=>
    ctl_out.mcu_run == $past(bus_req.wdata[CTRL_MCU_RUN]))
    else $error("run control not applied");

  chk_ptr_read: assert property (
    bus_req.rd && bus_req.addr == OFS_PTR |=> bus_rdata == DATA_W'($past(st.ptr)))
    else $error("pointer read wrong");

  chk_flags_read: assert property (
    bus_req.rd && bus_req.addr == OFS_FLAGS |=> bus_rdata == $past(st.flags))
    else $error("flags read wrong");

  chk_base_read: assert property (
    bus_req.rd && bus_req.addr == OFS_BASE |=> bus_rdata == DATA_W'($past(st.rate_ok)))
    else $error("rate mask read wrong");

  chk_ctrl_read: assert property (
    bus_req.rd && bus_req.addr == OFS_CTRL |=> bus_rdata == DATA_W'($past(st.mcu_run)))
    else $error("control read wrong");

  chk_rate_read: assert property (
    bus_req.rd && bus_req.addr == OFS_RATE |=>
    bus_rdata[1:0] == $past(st.rate) && bus_rdata[RATE_ERR_BIT] == $past(st.rate_err))
    else $error("rate read wrong");

  chk_status_read: assert property (
    bus_req.rd && bus_req.addr == OFS_STATUS |=>
    bus_rdata[ST_MCU_RUN] == $past(st.mcu_run) &&
    bus_rdata[ST_BASE_DONE] == $past(st.base_done) &&
    bus_rdata[ST_RATE_VALID] == $past(st.rate_valid) &&
    bus_rdata[ST_RATE_ERR] == $past(st.rate_err))
    else $error("status read wrong");

  chk_unmapped_write: assert property (
    bus_req.wr && !mapped |=>
    st.ptr == $past(st.ptr) && st.flags == $past(st.flags) && st.rate == $past(st.rate) &&
    st.mcu_run == $past(st.mcu_run) && st.rate_err == $past(st.rate_err))
    else $error("unmapped write changed state");

  cov_inc_burst: cover property (
    bus_req.wr && sel_inc ##1 bus_req.wr && sel_inc ##1 bus_req.rd && sel_inc);

  cov_rate_ok: cover property (
    bus_req.wr && bus_req.addr == OFS_BASE ##[1:4] st.rate_valid);

  cov_rate_err: cover property ($rose(st.rate_err));

  cov_mcu_fetch: cover property (st.mcu_run && mcu_req.en && !mcu_req.we);

  cov_plain_rw: cover property (bus_req.wr && sel_dat ##[1:4] bus_req.rd && sel_dat);
endmodule : ssm_portal

// *** verification/ssm_mcu_model.sv ***
`timescale 1ns/100ps
module ssm_mcu_model (
  input wire logic clk,
  input wire logic [ssm_pkg::DATA_W-1:0] mcu_rdata,
  output ssm_pkg::ssm_mcu_req_t mcu_req
);
  import ssm_pkg::*;
  initial mcu_req = '0;
  // one firmware access, held for one clock cycle whether taken or not, then lines scrambled
  task fw_acc(input logic we, input logic [PTR_W-1:0] a,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    @(posedge clk);
    mcu_req <= '{addr: a, wdata: d, en: 1'b1, we: we};
    @(posedge clk);
    mcu_req <= '{addr: ~a, wdata: ~d, en: 1'b0, we: ~we};
    @(posedge clk);
    q = mcu_rdata;
  endtask : fw_acc
endmodule : ssm_mcu_model

// *** verification/ssm_portal_tb_top.sv ***
`timescale 1ns/100ps
module ssm_portal_tb_top;
  import ssm_pkg::*;
  logic clk;
  logic nrst;
  ssm_bus_req_t req;
  logic [DATA_W-1:0] bus_rdata;
  ssm_mcu_req_t mcu_req;
  logic [DATA_W-1:0] mcu_rdata;
  ssm_ctl_out_t ctl_out;
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] er;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;

  ssm_portal ssm_portal_i (
    .clk(clk),
    .nrst(nrst),
    .bus_req(req),
    .bus_rdata(bus_rdata),
    .mcu_req(mcu_req),
    .mcu_rdata(mcu_rdata),
    .ctl_out(ctl_out)
  );

  ssm_mcu_model ssm_mcu_model_i (
    .clk(clk),
    .mcu_rdata(mcu_rdata),
    .mcu_req(mcu_req)
  );

  initial clk = 1'b0;
  always #20 clk = ~clk;

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fail_count++;
      give_verdict;
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    d = bus_rdata;
  endtask : rd_reg

  initial
  begin
    nrst = 1'b0;
    req = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(OFS_PTR, q);
    chk(q, 32'h0);
    chk(32'(ctl_out), 32'h0);
    chk(32'(ctl_out.mcu_run), 32'h0);
    wr_reg(OFS_PTR, 32'hFFFF_FFFF);
    rd_reg(OFS_PTR, q);
    chk(q, 32'h0000_3FFF);
    wr_reg(OFS_DATINC, 32'hC0DE_0001);
    rd_reg(OFS_PTR, q);
    chk(q, 32'h0);
    wr_reg(OFS_PTR, 32'h5);
    wr_reg(OFS_DATINC, 32'hA5A5_0005);
    wr_reg(OFS_DAT, 32'h5A5A_0006);
    rd_reg(OFS_DAT, q);
    chk(q, 32'h5A5A_0006);
    rd_reg(OFS_PTR, q);
    chk(q, 32'h6);
    wr_reg(OFS_PTR, 32'h5);
    rd_reg(OFS_DATINC, q);
    chk(q, 32'hA5A5_0005);
    rd_reg(OFS_DATINC, q);
    chk(q, 32'h5A5A_0006);
    rd_reg(OFS_PTR, q);
    chk(q, 32'h7);
    wr_reg(OFS_PTR, 32'h3FFF);
    rd_reg(OFS_DAT, q);
    chk(q, 32'hC0DE_0001);
    rd_reg(8'h20, q);
    chk(q, 32'h0);
    wr_reg(8'h20, 32'hFFFF_FFFF);
    rd_reg(OFS_PTR, q);
    chk(q, 32'h0000_3FFF);
    wr_reg(OFS_RATE, 32'(RATE_HALF));
    rd_reg(OFS_STATUS, q);
    chk(q & 32'hF, 32'h8);
    wr_reg(OFS_BASE, 32'h3);
    er = 32'h0;
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(OFS_STATUS, 32'h8);
      wr_reg(OFS_RATE, 32'(i));
      if (i < 2)
        er = 32'(i);
      rd_reg(OFS_RATE, q);
      chk(q, (i < 2) ? er : (er | 32'h100));
      chk(32'(ctl_out.lane_rate), er);
    end
    chk(32'(ctl_out.rate_valid), 32'h1);
    rd_reg(OFS_BASE, q);
    chk(q, 32'h3);
    ssm_mcu_model_i.fw_acc(1'b0, 14'h6, 32'h0, q);
    chk(q, 32'h0);
    ssm_mcu_model_i.fw_acc(1'b1, 14'h6, 32'hDEAD_0006, q);
    wr_reg(OFS_CTRL, 32'h1);
    rd_reg(OFS_CTRL, q);
    chk(q, 32'h1);
    wr_reg(OFS_FLAGS, 32'h0000_00A5);
    rd_reg(OFS_FLAGS, q);
    chk(ctl_out.cfg_flags, 32'h0000_00A5);
    chk(q, 32'h0000_00A5);
    chk(32'(ctl_out.mcu_run), 32'h1);
    ssm_mcu_model_i.fw_acc(1'b0, 14'h6, 32'h0, q);
    chk(q, 32'h5A5A_0006);
    ssm_mcu_model_i.fw_acc(1'b1, 14'h9, 32'hBEEF_0009, q);
    wr_reg(OFS_PTR, 32'h9);
    rd_reg(OFS_DAT, q);
    chk(q, 32'hBEEF_0009);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(OFS_STATUS, q);
    chk(q, 32'h0);
    chk(32'(ctl_out.mcu_run), 32'h0);
    chk(32'(ctl_out.rate_valid), 32'h0);
    chk(ctl_out.cfg_flags, 32'h0);
    rd_reg(OFS_PTR, q);
    chk(q, 32'h0);
    wr_reg(OFS_PTR, 32'h9);
    rd_reg(OFS_DAT, q);
    chk(q, 32'hBEEF_0009);
    give_verdict;
  end
endmodule : ssm_portal_tb_top
